// ---- rtl/run_supervisor_pkg.sv ----
// package: constants, codes and register map of the run command supervisor
package run_supervisor_pkg;
  // =====================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [6:0]  DC_TIME_MULT   = 7'h64;
  localparam logic [6:0]  DECEL_MS_UNIT  = 7'h64;
  // =====================================================
  // register map
  localparam logic [7:0]  CFG_ADDR   = 8'h00;
  localparam logic [7:0]  TIME_ADDR  = 8'h04;
  localparam logic [7:0]  FREQ_ADDR  = 8'h08;
  localparam logic [7:0]  BRAKE_ADDR = 8'h0c;
  localparam logic [7:0]  STAT_ADDR  = 8'h10;
  localparam logic [31:0] CFG_RST    = 32'h0000_0005;
  localparam logic [31:0] TIME_RST   = 32'h0032_01f4;
  localparam logic [31:0] FREQ_RST   = 32'h0064_1770;
  localparam logic [31:0] BRAKE_RST  = 32'h0000_0032;
  // cfg fields
  localparam int CFG_RUN_LSB  = 0;
  localparam int CFG_REF_LSB  = 2;
  localparam int CFG_STOP_LSB = 5;
  localparam int CFG_REVINH   = 7;
  localparam int CFG_SWPOL    = 8;
  localparam int CFG_PGM_LSB  = 9;
  localparam int CFG_PHASE    = 11;
  localparam int CFG_ARUN_LSB = 12;
  localparam int CFG_AREF_LSB = 14;
  localparam int CFG_PUACC    = 17;
  localparam int CFG_PMOLV    = 18;
  localparam int CFG_3WIRE    = 19;
  // =====================================================
  // codes
  localparam logic [1:0] SRC_KEYPAD = 2'h0;
  localparam logic [1:0] SRC_TERM   = 2'h1;
  localparam logic [1:0] SRC_SERIAL = 2'h2;
  localparam logic [1:0] SRC_OPTION = 2'h3;
  localparam logic [2:0] REF_OPTION = 3'h3;
  localparam logic [1:0] STOP_RAMP  = 2'h0;
  localparam logic [1:0] STOP_COAST = 2'h1;
  localparam logic [1:0] STOP_DCINJ = 2'h2;
  localparam logic [1:0] STOP_TIMER = 2'h3;
  localparam logic [1:0] PGM_BLOCK  = 2'h0;
  localparam logic [1:0] PGM_NOPROG = 2'h2;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CS_LOCAL   = 2'b00,
    CS_REMOTE1 = 2'b01,
    CS_REMOTE2 = 2'b10
  } ctrl_src_e;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RUN   = 3'b001,
    ST_RAMP  = 3'b010,
    ST_OFF   = 3'b011,
    ST_DCINJ = 3'b100,
    ST_WAIT  = 3'b101
  } stop_state_e;
endpackage

// ---- rtl/ms_down_timer.sv ----
// millisecond down-counter with load and busy flag
`timescale 1ns/10ps
module ms_down_timer #(
  parameter int unsigned TICK = 50000
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        load,
  input  wire logic [19:0] load_ms,
  output logic             busy
);
  localparam int PW = $clog2(TICK);
  localparam logic [PW-1:0] PRE_TOP = PW'(TICK - 1);

  logic [PW-1:0] pre_r;
  logic [19:0]   ms_r;

  // =====================================================
  // prescaler restarts on load so every millisecond is whole
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= '0;
    end else if (load || pre_r == PRE_TOP) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_r <= '0;
    end else if (load) begin
      ms_r <= load_ms;
    end else if (pre_r == PRE_TOP && ms_r != 20'h00000) begin
      ms_r <= ms_r - 1'b1;
    end
  end

  assign busy = (ms_r != 20'h00000);
endmodule

// ---- rtl/run_command_supervisor.sv ----
// run/stop source selection, stop sequencing and run lockouts
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
module run_command_supervisor
  import run_supervisor_pkg::*;
#(
  parameter int unsigned TICK = TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // axi4-lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // pins
  input  wire logic        keypad_run_key,
  input  wire logic        keypad_stop_key,
  input  wire logic        keypad_rev,
  input  wire logic        term_s1,
  input  wire logic        term_s2,
  input  wire logic        term_s5,
  input  wire logic        option_present,
  input  wire logic        local_remote_key,
  input  wire logic        ref2_select,
  // same-clock logic
  input  wire logic        serial_run,
  input  wire logic        serial_rev,
  input  wire logic        option_run,
  input  wire logic        option_rev,
  input  wire logic        ref_negative,
  input  wire logic        program_mode,
  input  wire logic        startup_done,
  input  wire logic [15:0] output_frequency,
  // power stage
  output logic             run_permit,
  output logic             dir_reverse,
  output logic             phase_swap,
  output logic             ramp_stop_req,
  output logic             output_off,
  output logic             dc_inject_req,
  output logic [6:0]       dc_current_level,
  output logic             ref_zero_clamp,
  output logic             program_entry_allow,
  output logic             option_missing_error,
  output logic             run_fast_flash
);
  localparam int NPIN = 9;

  // =====================================================
  // functions
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [19:0] scale_ms(input logic [15:0] t, input logic [6:0] k,
                                           input logic [15:0] f, input logic [15:0] fm);
    logic [39:0] q;
    q = (40'(t) * 40'(k) * 40'(f)) / 40'((fm == 16'h0000) ? 16'h0001 : fm);
    return (q > 40'h00000fffff) ? 20'hfffff : q[19:0];
  endfunction

  // =====================================================
  // pin synchronisers
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] meta_r;
  logic [NPIN-1:0] pin_r;
  logic [NPIN-1:0] pin_d_r;

  assign pin_raw = {ref2_select, local_remote_key, option_present, term_s5, term_s2,
                    term_s1, keypad_rev, keypad_stop_key, keypad_run_key};

  generate
    for (genvar g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[g]  <= 1'b0;
          pin_r[g]   <= 1'b0;
          pin_d_r[g] <= 1'b0;
        end else begin
          meta_r[g]  <= pin_raw[g];
          pin_r[g]   <= meta_r[g];
          pin_d_r[g] <= pin_r[g];
        end
      end
    end
  endgenerate

  logic [NPIN-1:0] pin_rise;
  assign pin_rise = pin_r & ~pin_d_r;

  // =====================================================
  // registers
  logic [31:0] cfg_r;
  logic [31:0] time_r;
  logic [31:0] freq_r;
  logic [31:0] brake_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic [31:0] status;
  logic        wr_fire;

  assign awready = !aw_hold_r && !bvalid_r;
  assign wready  = !w_hold_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_hold_r  <= 1'b0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= awaddr;
      end else if (wr_fire) begin
        aw_hold_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end else if (wr_fire) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r    <= CFG_RST;
      time_r   <= TIME_RST;
      freq_r   <= FREQ_RST;
      brake_r  <= BRAKE_RST;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= RESP_OKAY;
      case (aw_addr_r)
        CFG_ADDR:   cfg_r   <= merge(cfg_r, w_data_r, w_strb_r) & 32'h000f_ffff;
        TIME_ADDR:  time_r  <= merge(time_r, w_data_r, w_strb_r);
        FREQ_ADDR:  freq_r  <= merge(freq_r, w_data_r, w_strb_r);
        BRAKE_ADDR: brake_r <= merge(brake_r, w_data_r, w_strb_r) & 32'h0000_007f;
        STAT_ADDR:  bresp_r <= RESP_OKAY;
        default:    bresp_r <= RESP_SLVERR;
      endcase
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      case (araddr)
        CFG_ADDR:   rdata_r <= cfg_r;
        TIME_ADDR:  rdata_r <= time_r;
        FREQ_ADDR:  rdata_r <= freq_r;
        BRAKE_ADDR: rdata_r <= brake_r;
        STAT_ADDR:  rdata_r <= status;
        default: begin
          rdata_r <= '0;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // =====================================================
  // settings
  logic [1:0]  primary_run_source_select;
  logic [2:0]  primary_ref_source_select;
  logic [1:0]  stop_method_select;
  logic        reverse_inhibit;
  logic        source_switch_run_policy;
  logic [1:0]  program_mode_run_policy;
  logic [1:0]  alternate_run_source_select;
  logic [2:0]  alternate_ref_source_select;
  logic        powerup_run_accept;
  logic        pm_olv_mode;
  logic        three_wire;
  logic [15:0] min_output_off_time;
  logic [15:0] dc_brake_stop_time;
  logic [15:0] max_output_frequency;
  logic [15:0] default_decel_time;

  assign primary_run_source_select   = cfg_r[CFG_RUN_LSB +: 2];
  assign primary_ref_source_select   = cfg_r[CFG_REF_LSB +: 3];
  assign stop_method_select          = cfg_r[CFG_STOP_LSB +: 2];
  assign reverse_inhibit             = cfg_r[CFG_REVINH];
  assign source_switch_run_policy    = cfg_r[CFG_SWPOL];
  assign program_mode_run_policy     = cfg_r[CFG_PGM_LSB +: 2];
  assign alternate_run_source_select = cfg_r[CFG_ARUN_LSB +: 2];
  assign alternate_ref_source_select = cfg_r[CFG_AREF_LSB +: 3];
  assign powerup_run_accept          = cfg_r[CFG_PUACC];
  assign pm_olv_mode                 = cfg_r[CFG_PMOLV];
  assign three_wire                  = cfg_r[CFG_3WIRE];
  assign min_output_off_time         = time_r[15:0];
  assign dc_brake_stop_time          = time_r[31:16];
  assign max_output_frequency        = freq_r[15:0];
  assign default_decel_time          = freq_r[31:16];
  assign dc_current_level            = brake_r[6:0];
  assign phase_swap                  = cfg_r[CFG_PHASE];

  // =====================================================
  // control source
  logic       local_r;
  ctrl_src_e  ctrl_src;
  logic [1:0] run_src;
  logic [2:0] ref_src;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      local_r <= 1'b0;
    end else if (pin_rise[7]) begin
      local_r <= !local_r;
    end
  end

  assign ctrl_src = local_r ? CS_LOCAL : (pin_r[8] ? CS_REMOTE2 : CS_REMOTE1);
  assign run_src  = (ctrl_src == CS_LOCAL)   ? SRC_KEYPAD :
                    (ctrl_src == CS_REMOTE2) ? alternate_run_source_select :
                                               primary_run_source_select;
  assign ref_src  = (ctrl_src == CS_REMOTE2) ? alternate_ref_source_select :
                                               primary_ref_source_select;
  assign option_missing_error = (ctrl_src != CS_LOCAL) && ref_src == REF_OPTION &&
                                !pin_r[6];

  // =====================================================
  // keypad and terminal sequences
  logic kp_run_r;
  logic tw_run_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kp_run_r <= 1'b0;
    end else if (pin_rise[1] || run_src != SRC_KEYPAD) begin
      kp_run_r <= 1'b0;
    end else if (pin_rise[0]) begin
      kp_run_r <= 1'b1;
    end
  end

  // three-wire: s1 start pulse, s2 normally closed stop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tw_run_r <= 1'b0;
    end else if (!pin_r[4] || !three_wire) begin
      tw_run_r <= 1'b0;
    end else if (pin_rise[3]) begin
      tw_run_r <= 1'b1;
    end
  end

  logic src_run;
  logic src_rev;

  always_comb begin
    src_run = 1'b0;
    src_rev = 1'b0;
    case (run_src)
      SRC_KEYPAD: begin
        src_run = kp_run_r;
        src_rev = pin_r[2];
      end
      SRC_TERM: begin
        if (three_wire) begin
          src_run = tw_run_r;
          src_rev = pin_r[5];
        end else begin
          src_run = pin_r[3] ^ pin_r[4];
          src_rev = pin_r[4] && !pin_r[3];
        end
      end
      SRC_SERIAL: begin
        src_run = serial_run;
        src_rev = serial_rev;
      end
      SRC_OPTION: begin
        src_run = option_run;
        src_rev = option_rev;
      end
      default: begin
        src_run = 1'b0;
        src_rev = 1'b0;
      end
    endcase
  end

  logic run_req;
  assign run_req        = src_run && !(src_rev && reverse_inhibit);
  assign ref_zero_clamp = reverse_inhibit && ref_negative;

  // =====================================================
  // cycling lockouts
  stop_state_e state_r;
  logic [1:0]  prev_src_r;
  logic        started_r;
  logic        cycle_lock_r;
  logic        pu_flag_r;
  logic        switch_lock;
  logic        pu_lock;
  logic        wait_lock;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_src_r <= SRC_KEYPAD;
      started_r  <= 1'b0;
    end else begin
      prev_src_r <= run_src;
      started_r  <= startup_done;
    end
  end

  assign switch_lock = run_src != prev_src_r && !source_switch_run_policy &&
                       src_run;
  assign pu_lock     = startup_done && !started_r && src_run &&
                       !powerup_run_accept;
  assign wait_lock   = state_r == ST_WAIT && src_run;

  // set wins over the clear by the run removal
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle_lock_r <= 1'b0;
      pu_flag_r    <= 1'b0;
    end else begin
      if (switch_lock || pu_lock || wait_lock) begin
        cycle_lock_r <= 1'b1;
      end else if (!src_run) begin
        cycle_lock_r <= 1'b0;
      end
      if (pu_lock) begin
        pu_flag_r <= 1'b1;
      end else if (!src_run) begin
        pu_flag_r <= 1'b0;
      end
    end
  end

  assign run_fast_flash = pu_flag_r;

  logic prog_block;
  logic start_ok;
  assign prog_block = program_mode && program_mode_run_policy == PGM_BLOCK;
  assign start_ok   = run_req && !cycle_lock_r && !option_missing_error &&
                      !prog_block && started_r && !switch_lock && !pu_lock;

  // =====================================================
  // stop sequencer
  logic        tmr_load;
  logic [19:0] tmr_ms;
  logic        tmr_busy;
  logic        dc_pend_r;
  logic [19:0] dc_ms_r;
  logic        dir_r;

  ms_down_timer #(
    .TICK (TICK)
  ) u_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .load    (tmr_load),
    .load_ms (tmr_ms),
    .busy    (tmr_busy)
  );

  always_comb begin
    tmr_load = 1'b0;
    tmr_ms   = {4'h0, min_output_off_time};
    if (state_r == ST_RUN && !start_ok) begin
      case (stop_method_select)
        STOP_COAST, STOP_DCINJ: tmr_load = 1'b1;
        STOP_TIMER: begin
          tmr_load = 1'b1;
          tmr_ms   = scale_ms(default_decel_time, DECEL_MS_UNIT, output_frequency,
                              max_output_frequency);
        end
        default: tmr_load = 1'b0;
      endcase
    end else if (state_r == ST_OFF && !tmr_busy && dc_pend_r) begin
      tmr_load = 1'b1;
      tmr_ms   = dc_ms_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      dc_pend_r <= 1'b0;
      dc_ms_r   <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_ok) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!start_ok) begin
            dc_ms_r   <= scale_ms(dc_brake_stop_time, DC_TIME_MULT, output_frequency,
                                  max_output_frequency);
            dc_pend_r <= stop_method_select == STOP_DCINJ && !pm_olv_mode;
            case (stop_method_select)
              STOP_RAMP:  state_r <= ST_RAMP;
              STOP_TIMER: state_r <= ST_WAIT;
              default:    state_r <= ST_OFF;
            endcase
          end
        end
        ST_RAMP: begin
          if (start_ok) begin
            state_r <= ST_RUN;
          end else if (output_frequency == 16'h0000) begin
            state_r <= ST_IDLE;
          end
        end
        ST_OFF: begin
          if (!tmr_busy) begin
            state_r   <= dc_pend_r ? ST_DCINJ : ST_IDLE;
            dc_pend_r <= 1'b0;
          end
        end
        ST_DCINJ, ST_WAIT: begin
          if (!tmr_busy) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_r <= 1'b0;
    end else if (start_ok) begin
      dir_r <= src_rev;
    end
  end

  // =====================================================
  // outputs
  assign run_permit          = state_r == ST_RUN;
  assign ramp_stop_req       = state_r == ST_RAMP;
  assign dc_inject_req       = state_r == ST_DCINJ;
  assign output_off          = state_r == ST_OFF || state_r == ST_WAIT || state_r == ST_IDLE;
  assign dir_reverse         = dir_r;
  assign program_entry_allow = !(program_mode_run_policy == PGM_NOPROG &&
                                 (state_r == ST_RUN || state_r == ST_RAMP ||
                                  state_r == ST_DCINJ));
  assign status = {21'h0, tmr_busy, ctrl_src, state_r, pu_flag_r, option_missing_error,
                   cycle_lock_r, dir_r, run_permit};
endmodule

// ---- tb/run_sup_chk.sv ----
// port checker for the run command supervisor
`timescale 1ns/10ps
module run_sup_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        startup_done,
  input wire logic [15:0] output_frequency,
  input wire logic        option_missing_error,
  input wire logic        run_permit,
  input wire logic        output_off,
  input wire logic        ramp_stop_req,
  input wire logic        dc_inject_req,
  input wire logic        ref_zero_clamp,
  input wire logic        ref_negative,
  input wire logic        program_entry_allow
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // =====================================================
  // properties
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  property p_permit_only;
    run_permit |-> !output_off && !dc_inject_req && !ramp_stop_req;
  endproperty
  property p_clamp;
    ref_zero_clamp |-> ref_negative;
  endproperty
  property p_opt;
    option_missing_error |=> !run_permit;
  endproperty
  property p_prog;
    !program_entry_allow |-> !output_off;
  endproperty
  property p_start;
    $rose(run_permit) |-> $past(startup_done, 2);
  endproperty
  property p_ramp;
    ramp_stop_req && output_frequency == 16'h0 |=> !ramp_stop_req;
  endproperty
  property p_rd;
    s_rd_take |=> rvalid;
  endproperty
  property p_bhold;
    bvalid && !bready |=> bvalid;
  endproperty
  a_permit_only: assert property (p_permit_only) else $error("permit outside run");
  a_clamp: assert property (p_clamp) else $error("clamp without negative");
  a_opt: assert property (p_opt) else $error("run with option error");
  a_prog: assert property (p_prog) else $error("entry blocked while off");
  a_start: assert property (p_start) else $error("run before start-up");
  a_ramp: assert property (p_ramp) else $error("ramp past zero");
  a_rd: assert property (p_rd) else $error("read answer late");
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
endmodule
bind run_command_supervisor run_sup_chk chk (.clk, .rst_n, .arvalid, .arready, .rvalid,
  .bvalid, .bready, .startup_done, .output_frequency, .option_missing_error, .run_permit,
  .output_off, .ramp_stop_req, .dc_inject_req, .ref_zero_clamp, .ref_negative,
  .program_entry_allow);

// ---- tb/host_model.sv ----
// far side model: serial host, option board and terminal run levels
`timescale 1ns/10ps
module host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run_cmd,
  input  wire logic rev_cmd,
  output logic      serial_run,
  output logic      serial_rev,
  output logic      option_run,
  output logic      option_rev,
  output logic      term_s1,
  output logic      term_s2,
  output logic      term_s5
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {serial_run, serial_rev, option_run, option_rev} <= 4'h0;
      {term_s1, term_s2, term_s5} <= 3'h0;
    end else begin
      {serial_run, option_run} <= {2{run_cmd}};
      {serial_rev, option_rev, term_s5} <= {3{rev_cmd}};
      term_s1 <= run_cmd & !rev_cmd;
      term_s2 <= run_cmd & rev_cmd;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the run command supervisor
`timescale 1ns/10ps
module tb_top
  import run_supervisor_pkg::*;
;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, option_present;
  logic        startup_done, ref_negative, program_mode, run_cmd, rev_cmd;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [15:0] output_frequency;
  logic        awready, wready, bvalid, arready, rvalid, run_permit, dir_reverse;
  logic        phase_swap, output_off, ref_zero_clamp, option_missing_error;
  logic        serial_run, serial_rev, option_run, option_rev, term_s1, term_s2, term_s5;
  logic [1:0]  bresp, rresp;
  logic [6:0]  dc_current_level;
  logic        ref2_select, program_entry_allow;
  int          error_cnt = 0;
  int          tests_run = 0;
  // =====================================================
  // instances
  run_command_supervisor #(.TICK(10)) uut (.clk, .rst_n, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .keypad_run_key(1'h0),
    .keypad_stop_key(1'h0), .keypad_rev(1'h0), .term_s1, .term_s2, .term_s5,
    .option_present, .local_remote_key(1'h0), .ref2_select, .serial_run,
    .serial_rev, .option_run, .option_rev, .ref_negative, .program_mode, .startup_done,
    .output_frequency, .run_permit, .dir_reverse, .phase_swap, .ramp_stop_req(),
    .output_off, .dc_inject_req(), .dc_current_level, .ref_zero_clamp,
    .program_entry_allow, .option_missing_error, .run_fast_flash());
  host_model host (.clk, .rst_n, .run_cmd, .rev_cmd, .serial_run, .serial_rev,
    .option_run, .option_rev, .term_s1, .term_s2, .term_s5);
  always #10 clk = ~clk;
  // =====================================================
  // helpers
  task automatic give_verdict();
    $display("tests %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 300) begin
      error_cnt++;
      $display("ERROR %0t: wait ran out", $time);
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    for (n = 0; n < 300; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0;
    tmo(n);
    chk(bresp, RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    for (n = 0; n < 300; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rready <= 1'h0;
    tmo(n);
    chk(rdata, e);
    chk(rresp, r);
  endtask
  task automatic wait_permit(input logic v);
    int n;
    for (n = 0; n < 300 && run_permit !== v; n++) @(posedge clk);
    tmo(n);
  endtask
  // =====================================================
  // scenarios
  task automatic t_regs();
    rd(CFG_ADDR, 32'h0000_0005, RESP_OKAY);
    rd(BRAKE_ADDR, 32'h0000_0032, RESP_OKAY);
    chk(dc_current_level, 32'h0000_0032);
    rd(8'h14, 32'h0, RESP_SLVERR);
    $display("end regs");
  endtask
  task automatic t_coast();
    wr(TIME_ADDR, 32'h0032_0003);
    wr(CFG_ADDR, {25'h0, STOP_COAST, 3'h1, SRC_SERIAL});
    run_cmd <= 1'h1;
    wait_permit(1'h1);
    run_cmd <= 1'h0;
    wait_permit(1'h0);
    @(posedge clk);
    chk(output_off, 1'h1);
    run_cmd <= 1'h1;
    repeat (20) @(posedge clk);
    chk(run_permit, 1'h0);
    wait_permit(1'h1);
    run_cmd <= 1'h0;
    wait_permit(1'h0);
    $display("end coast");
  endtask
  task automatic t_option();
    wr(CFG_ADDR, {27'h0, REF_OPTION, SRC_OPTION});
    repeat (4) @(posedge clk);
    chk(option_missing_error, 1'h1);
    run_cmd <= 1'h1;
    repeat (10) @(posedge clk);
    chk(run_permit, 1'h0);
    option_present <= 1'h1;
    wait_permit(1'h1);
    run_cmd <= 1'h0;
    wait_permit(1'h0);
    option_present <= 1'h0;
    $display("end option");
  endtask
  task automatic t_rev();
    wr(CFG_ADDR, {24'h0, 1'h1, STOP_RAMP, 3'h1, SRC_SERIAL});
    run_cmd      <= 1'h1;
    rev_cmd      <= 1'h1;
    ref_negative <= 1'h1;
    repeat (10) @(posedge clk);
    chk(run_permit, 1'h0);
    chk(ref_zero_clamp, 1'h1);
    wr(CFG_ADDR, {20'h0, 1'h1, 4'h0, STOP_RAMP, 3'h1, SRC_SERIAL});
    wait_permit(1'h1);
    @(posedge clk);
    chk(dir_reverse, 1'h1);
    chk(phase_swap, 1'h1);
    program_mode <= 1'h1;
    wait_permit(1'h0);
    {program_mode, run_cmd, rev_cmd, ref_negative} <= 4'h0;
    $display("end reverse");
  endtask
  task automatic t_switch();
    wr(CFG_ADDR, 32'h0000_3406);
    run_cmd <= 1'h1;
    wait_permit(1'h1);
    chk(program_entry_allow, 1'h0);
    ref2_select <= 1'h1;
    wait_permit(1'h0);
    repeat (10) @(posedge clk);
    chk(run_permit, 1'h0);
    chk(program_entry_allow, 1'h1);
    run_cmd <= 1'h0;
    repeat (3) @(posedge clk);
    run_cmd <= 1'h1;
    wait_permit(1'h1);
    {run_cmd, ref2_select} <= 2'h0;
    wait_permit(1'h0);
    $display("end switch");
  endtask
  initial begin
    {clk, rst_n, awvalid, wvalid, bready, arvalid, rready, option_present} = 8'h0;
    {startup_done, ref_negative, program_mode, run_cmd, rev_cmd, ref2_select} = 6'h0;
    {awaddr, araddr, wdata, output_frequency} = 64'h0;
    wstrb = 4'hf;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    startup_done <= 1'h1;
    repeat (3) @(posedge clk);
    t_regs();
    t_coast();
    t_option();
    t_rev();
    t_switch();
    give_verdict();
  end
endmodule
